/* rtl/accel_sample_buffer_control.sv */
// control of the 32-entry acceleration sample buffer
// What this block does
// - gated-drop flag stays set until buffer emptied or flushed.
// - triggered capture with autosleep count nonzero ignores transition hold.
// - hold keeps stored set across transitions; collection resumes after flush.
// - collection control bit 3 enables inside-band trigger, default off.
// - collection control bit 2 enables outside-band trigger, default off.
// - collection control bit 0 enables tilt-change trigger, default off.
// - flush on disable, flush command, or transition with hold cleared.
// - flush when leaving standby into active or external-trigger mode.
// - disabling clears overflow, watermark flag and sample count.
// - gated-drop flag and count reset on disable, flush or full readout.
// - triggered capture, count nonzero, active set: enter wake at once.
// - after count output-rate periods, flush and enter sleep.
// - before trigger, keep at most watermark samples circularly in sleep.
// - trigger moves to wake, held there, later triggers ignored.
// - after trigger store 32 minus watermark, set overflow, then stop.
// - empty or flush re-arms; new capture only after returning to sleep.
// - wake-to-sleep in triggered auto-sleep always flushes.
// - with autosleep count nonzero, anything blocking sleep also blocks triggered capture.
// - mode field: 01 stream overwrite, 10 stop when full, 11 triggered.
// - while hold engaged, drop samples, flag it and count drops.
// - flush command bit clears itself and reads back as zero.
// - watermark flag when count reaches level; level zero disables it.
module accel_sample_buffer_control
  import accel_buf_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // register port
  input  wire logic                  regWrite,
  input  wire logic                  regRead,
  input  wire logic [7:0]            regAddr,
  input  wire logic [7:0]            regWrData,
  output logic [7:0]                 regRdData,
  // power mode context
  input  wire logic                  activeBit,
  input  wire logic                  external_trigger_mode,
  input  wire logic [ASLP_W-1:0]     autosleep_period_count,
  input  wire logic                  outputRateTick,
  input  wire logic                  autoWakeEvt,
  input  wire logic                  autoSleepEvt,
  input  wire logic                  sleepBlocked,
  input  wire trig_events_t          trigEvents,
  // sample input
  input  wire logic                  sampleValid,
  input  wire sample_t               sampleData,
  output logic                       sampleReady,
  // host readout
  output logic                       outValid,
  input  wire logic                  outReady,
  output sample_t                    outData,
  // status
  output logic                       wakeMode,
  output logic                       overflow_flag,
  output logic                       watermarkFlag,
  output logic [CNT_W-1:0]           sampleCount,
  output logic                       gateDropFlag,
  output logic [GATE_CNT_W-1:0]      gateDropCount,
  output logic                       buffer_keeps_awake
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]       collectCtrl;
  logic [7:0]       threshCtrl;
  logic             flushCmd;
  collect_mode_t    mode;
  logic [CNT_W-1:0] watermark_level;
  logic             holdEnable;

  assign mode            = collect_mode_t'(collectCtrl[POS_MODE +: 2]);
  assign holdEnable      = collectCtrl[BIT_HOLD];
  assign watermark_level = threshCtrl[POS_WATERMARK +: CNT_W];
  assign buffer_keeps_awake = threshCtrl[BIT_KEEP_AWAKE];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      collectCtrl <= RST_COLLECTION_CTRL;
      threshCtrl  <= RST_THRESHOLD_CTRL;
    end else if (regWrite) begin
      if (regAddr == OFS_COLLECTION_CTRL) begin
        collectCtrl <= regWrData & MASK_COLLECTION;
      end
      if (regAddr == OFS_THRESHOLD_CTRL) begin
        threshCtrl <= regWrData & MASK_THRESHOLD;
      end
    end
  end

  // flush bit is only a one-cycle strobe, never stored
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flushCmd <= 1'b0;
    end else begin
      flushCmd <= regWrite && regAddr == OFS_THRESHOLD_CTRL
                  && regWrData[BIT_FLUSH];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        OFS_COLLECTION_CTRL: regRdData <= collectCtrl;
        OFS_THRESHOLD_CTRL:  regRdData <= threshCtrl;
        default:             regRdData <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode and capture sequencing

  capture_state_t   state;
  capture_state_t   next_state;
  logic             powered;
  logic             poweredQ;
  logic             trigAslp;
  logic             trigHit;
  logic             sleepFlush;
  logic [ASLP_W-1:0] aslpTimer;
  logic             wakeAuto;
  logic             autoTrans;
  logic             captureDone;
  logic             emptied;
  logic             flushNow;

  assign powered  = activeBit | external_trigger_mode;
  assign trigAslp = mode == MODE_TRIGGER && autosleep_period_count != '0;
  assign trigHit  = (trigEvents.insideBand  && collectCtrl[BIT_TRIG_INSIDE])
                 || (trigEvents.outsideBand && collectCtrl[BIT_TRIG_OUTSIDE])
                 || (trigEvents.tiltChange  && collectCtrl[BIT_TRIG_TILT]);
  assign sleepFlush = state == ST_WAKE && trigAslp && !sleepBlocked
                      && aslpTimer >= autosleep_period_count;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      poweredQ <= 1'b0;
    end else begin
      poweredQ <= powered;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (powered && trigAslp) begin
          next_state = ST_WAKE;
        end else if (powered && mode == MODE_TRIGGER) begin
          next_state = ST_ARMED;
        end
      end
      ST_WAKE: begin
        if (sleepFlush) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (trigHit) begin
          next_state = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (flushNow) begin
          next_state = trigAslp ? ST_WAKE : ST_ARMED;
        end else if (captureDone) begin
          next_state = ST_FULL;
        end
      end
      ST_FULL: begin
        if (flushNow || emptied) begin
          next_state = trigAslp ? ST_WAKE : ST_ARMED;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!powered || mode != MODE_TRIGGER) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // output-rate periods spent awake before sleeping
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aslpTimer <= '0;
    end else if (state != ST_WAKE || next_state != ST_WAKE) begin
      aslpTimer <= '0;
    end else if (outputRateTick && aslpTimer != '1) begin
      aslpTimer <= aslpTimer + 1'b1;
    end
  end

  // wake state driven by the auto-sleep function unless triggered capture has autosleep count nonzero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wakeAuto <= 1'b0;
    end else if (autoWakeEvt) begin
      wakeAuto <= 1'b1;
    end else if (autoSleepEvt && !sleepBlocked) begin
      wakeAuto <= 1'b0;
    end
  end

  assign autoTrans = !trigAslp && (wakeAuto ? autoSleepEvt && !sleepBlocked
                                            : autoWakeEvt);
  assign wakeMode = state inside {ST_CAPT, ST_FULL}
                    || (trigAslp ? state == ST_WAKE : wakeAuto);

  ////////////////////////////////////////////////////////////////////////////
  // flush and gate

  logic gateOn;
  logic [CNT_W-1:0] totalCount;

  assign flushNow = mode == MODE_OFF || flushCmd
                 || (autoTrans && !holdEnable)
                 || (powered && !poweredQ)
                 || sleepFlush;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gateOn <= 1'b0;
    end else if (autoTrans && holdEnable && totalCount != '0) begin
      gateOn <= 1'b1;
    end else if (flushNow || totalCount == '0) begin
      gateOn <= 1'b0;
    end
  end

  assign gateDropFlag = gateOn;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gateDropCount <= '0;
    end else if (flushNow || !gateOn || totalCount == '0) begin
      gateDropCount <= '0;
    end else if (sampleValid && gateDropCount != '1) begin
      gateDropCount <= gateDropCount + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage pointers

  logic [PTR_W-1:0] wrPtr;
  logic [PTR_W-1:0] rdPtr;
  logic [CNT_W-1:0] memCount;
  logic [CNT_W-1:0] postCount;
  logic             circular;
  logic             memFull;
  logic             doWrite;
  logic             dropOld;
  logic             doPop;
  logic             blocked;
  sample_t          memRdData;

  assign circular = state inside {ST_WAKE, ST_ARMED};
  assign memFull  = totalCount == FULL_COUNT;
  assign blocked  = flushNow || gateOn || state == ST_FULL
                 || (mode == MODE_STOP && memFull)
                 || (circular && watermark_level == '0);
  assign doWrite  = sampleValid && !blocked;
  assign dropOld  = doWrite && memCount != '0
                 && ((circular && memCount >= watermark_level)
                  || (mode == MODE_STREAM && memFull));
  assign sampleReady = 1'b1;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      memCount <= '0;
    end else if (flushNow) begin
      wrPtr    <= '0;
      rdPtr    <= '0;
      memCount <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doPop || dropOld) begin
        rdPtr <= rdPtr + 1'b1;
      end
      memCount <= memCount + CNT_W'(doWrite && !dropOld)
                           - CNT_W'(doPop);
    end
  end

  // samples taken since the trigger
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      postCount <= '0;
    end else if (state != ST_CAPT) begin
      postCount <= '0;
    end else if (doWrite) begin
      postCount <= postCount + 1'b1;
    end
  end

  assign captureDone = doWrite && postCount + 1'b1
                       == CNT_W'(FULL_COUNT - watermark_level);

  sample_store u_store (
    .clk    (clk),
    .wrEn   (doWrite),
    .wrAddr (wrPtr),
    .wrData (sampleData),
    .rdEn   (doPop),
    .rdAddr (rdPtr),
    .rdData (memRdData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // two-entry readout buffer

  sample_t    skid [2];
  logic [1:0] skidCount;
  logic       skidHead;
  logic       rdPend;
  logic       popOut;

  // circular storage stays in memory, so the pre-trigger count is exact
  assign doPop  = !flushNow && memCount != '0 && !dropOld && !circular
               && 2'(skidCount + 2'(rdPend)) < 2'h2;
  assign popOut = outValid && outReady;
  assign outValid = skidCount != '0;
  assign outData  = skid[skidHead];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdPend    <= 1'b0;
      skidCount <= '0;
      skidHead  <= 1'b0;
    end else if (flushNow) begin
      rdPend    <= 1'b0;
      skidCount <= '0;
      skidHead  <= 1'b0;
    end else begin
      rdPend    <= doPop;
      skidCount <= skidCount + 2'(rdPend) - 2'(popOut);
      if (popOut) begin
        skidHead <= !skidHead;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rdPend) begin
      skid[skidHead ^ skidCount[0]] <= memRdData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status

  logic ovfSet;

  assign totalCount = memCount + CNT_W'(skidCount) + CNT_W'(rdPend);
  assign emptied    = popOut && totalCount == 6'h01;
  assign sampleCount = totalCount;
  assign ovfSet = captureDone
               || (sampleValid && memFull && !blocked
                   && mode inside {MODE_STREAM, MODE_STOP})
               || (sampleValid && memFull && mode == MODE_STOP
                   && !gateOn && !flushNow);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
    end else if (ovfSet) begin
      overflow_flag <= 1'b1;
    end else if (flushNow || emptied) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      watermarkFlag <= 1'b0;
    end else begin
      watermarkFlag <= !flushNow && watermark_level != '0
                       && totalCount >= watermark_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_wakeEnd;
    state == ST_WAKE && sleepFlush;
  endsequence
  sequence s_sleepStart;
    state == ST_ARMED && memCount == '0;
  endsequence

  a_flush_clears: assert property (@(posedge clk) disable iff (!rst_b)
    flushNow |=> memCount == '0 && wrPtr == rdPtr && !overflow_flag)
    else $error("flush left stored samples");
  a_sleep_flush: assert property (@(posedge clk) disable iff (!rst_b)
    s_wakeEnd |=> s_sleepStart)
    else $error("sleep entry did not flush");
  a_flush_cmd_zero: assert property (@(posedge clk) disable iff (!rst_b)
    regRead && regAddr == OFS_THRESHOLD_CTRL |=> !regRdData[BIT_FLUSH])
    else $error("flush bit read as one");
  a_start_wake: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_IDLE && powered && trigAslp |=> wakeMode)
    else $error("no wake on triggered start");
  a_trig_hold: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_CAPT && !flushNow && !captureDone |=> state == ST_CAPT)
    else $error("capture left early");
  a_full_stop: assert property (@(posedge clk) disable iff (!rst_b)
    state == ST_FULL |-> !doWrite)
    else $error("write after capture full");
  a_gate_flag: assert property (@(posedge clk) disable iff (!rst_b)
    gateOn && totalCount != '0 && !flushNow |=> gateDropFlag)
    else $error("gate flag dropped early");
  a_wm_flag: assert property (@(posedge clk) disable iff (!rst_b)
    watermark_level == '0 |=> !watermarkFlag)
    else $error("watermark flag with level zero");
  a_disable_clr: assert property (@(posedge clk) disable iff (!rst_b)
    mode == MODE_OFF ##1 mode == MODE_OFF |-> sampleCount == '0
    && !overflow_flag && !watermarkFlag)
    else $error("disabled buffer not cleared");
  a_gate_drop: assert property (@(posedge clk) disable iff (!rst_b)
    gateOn |-> !doWrite)
    else $error("sample stored while gated");

endmodule

/* shared/accel_buf_pkg.sv */
// constants and types shared by the sample buffer control block
package accel_buf_pkg;

  // register map
  localparam logic [7:0] OFS_COLLECTION_CTRL = 8'h26;
  localparam logic [7:0] OFS_THRESHOLD_CTRL  = 8'h27;
  localparam logic [7:0] RST_COLLECTION_CTRL = 8'h00;
  localparam logic [7:0] RST_THRESHOLD_CTRL  = 8'h00;

  // collection control fields
  localparam int BIT_TRIG_TILT    = 0;
  localparam int BIT_TRIG_OUTSIDE = 2;
  localparam int BIT_TRIG_INSIDE  = 3;
  localparam int BIT_HOLD         = 4;
  localparam int POS_MODE         = 5;
  // bits 7 and 1 are held at zero
  localparam logic [7:0] MASK_COLLECTION = 8'h7D;

  // threshold control fields
  localparam int POS_WATERMARK  = 0;
  localparam int BIT_KEEP_AWAKE = 6;
  localparam int BIT_FLUSH      = 7;
  localparam logic [7:0] MASK_THRESHOLD = 8'h7F;

  // sizes
  localparam int DEPTH      = 32;
  localparam int PTR_W      = 5;
  localparam int CNT_W      = 6;
  localparam int AXIS_W     = 12;
  localparam int ASLP_W     = 16;
  localparam int GATE_CNT_W = 5;
  localparam logic [CNT_W-1:0] FULL_COUNT = 6'h20;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'h0,
    MODE_STREAM  = 2'h1,
    MODE_STOP    = 2'h2,
    MODE_TRIGGER = 2'h3
  } collect_mode_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_WAKE  = 5'h02,
    ST_ARMED = 5'h04,
    ST_CAPT  = 5'h08,
    ST_FULL  = 5'h10
  } capture_state_t;

  typedef struct packed {
    logic [AXIS_W-1:0] x;
    logic [AXIS_W-1:0] y;
    logic [AXIS_W-1:0] z;
  } sample_t;

  typedef struct packed {
    logic insideBand;
    logic outsideBand;
    logic tiltChange;
  } trig_events_t;

endpackage

/* rtl/sample_store.sv */
// 32-entry sample memory with registered read data
module sample_store
  import accel_buf_pkg::*;
(
  // clock
  input  wire logic             clk,
  // write port
  input  wire logic             wrEn,
  input  wire logic [PTR_W-1:0] wrAddr,
  input  wire sample_t          wrData,
  // read port
  input  wire logic             rdEn,
  input  wire logic [PTR_W-1:0] rdAddr,
  output sample_t               rdData
);

  sample_t mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule

/* testbench/host_model.sv */
// host side: register port master and readout drain with random stalls
module host_model
  import accel_buf_pkg::*;
(
  // clock
  input  wire logic       clk,
  // register port
  output logic            regWrite,
  output logic            regRead,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData,
  // readout
  input  wire logic       outValid,
  output logic            outReady,
  input  wire sample_t    outData
);
  timeunit 1ns;
  timeprecision 100ps;
  integer seed = 30;
  initial begin
    regWrite  = 1'b0;
    regRead   = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
    outReady  = 1'b0;
  end
  // released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    regWrite  = 1'b1;
    regAddr   = a;
    regWrData = d;
    @(posedge clk);
    #1;
    regWrite  = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    regRead = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
    d       = regRdData;
  endtask
  // take one word, stalling at random
  task automatic pop(output sample_t d, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 64 && !ok; i++) begin
      @(negedge clk);
      if (outValid && outReady) begin
        d  = outData;
        ok = 1'b1;
      end
      @(posedge clk);
      #1;
      outReady = ok ? 1'b0 : (($random(seed) & 1) != 0);
    end
  endtask
endmodule

/* testbench/tb.sv */
// self-checking bench for the sample buffer control block
module tb
  import accel_buf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic regWrite, regRead, outValid, outReady, sampleReady, sampleValid;
  logic [7:0] regAddr, regWrData, regRdData, rv, v;
  logic activeBit, external_trigger_mode, outputRateTick, sleepBlocked;
  logic autoWakeEvt, autoSleepEvt, wakeMode, overflow_flag, watermarkFlag;
  logic gateDropFlag, buffer_keeps_awake, ok;
  logic [ASLP_W-1:0] autosleep_period_count;
  logic [CNT_W-1:0] sampleCount;
  logic [GATE_CNT_W-1:0] gateDropCount;
  trig_events_t trigEvents;
  sample_t sampleData, outData, got;
  sample_t sent[$];
  logic [7:0] addrs[3] = '{OFS_COLLECTION_CTRL, OFS_THRESHOLD_CTRL, 8'h30};
  integer seed = 30;
  int bad_count = 0;
  int n_tests = 0;

  always #2 clk = ~clk;

  accel_sample_buffer_control uut (
    .clk(clk), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .activeBit(activeBit), .external_trigger_mode(external_trigger_mode),
    .autosleep_period_count(autosleep_period_count),
    .outputRateTick(outputRateTick), .autoWakeEvt(autoWakeEvt),
    .autoSleepEvt(autoSleepEvt), .sleepBlocked(sleepBlocked),
    .trigEvents(trigEvents), .sampleValid(sampleValid),
    .sampleData(sampleData), .sampleReady(sampleReady),
    .outValid(outValid), .outReady(outReady), .outData(outData),
    .wakeMode(wakeMode), .overflow_flag(overflow_flag),
    .watermarkFlag(watermarkFlag), .sampleCount(sampleCount),
    .gateDropFlag(gateDropFlag), .gateDropCount(gateDropCount),
    .buffer_keeps_awake(buffer_keeps_awake));

  host_model host (
    .clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .outValid(outValid),
    .outReady(outReady), .outData(outData));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [CNT_W-1:0] capCount(input int n);
    return (n > DEPTH) ? FULL_COUNT : CNT_W'(n);
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e,
                     input string m);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      step();
      sampleValid = 1'b1;
      sampleData  = sample_t'(36'({$random(seed), $random(seed)}));
      sent.push_back(sampleData);
    end
    step();
    sampleValid = 1'b0;
  endtask
  task automatic drain(input int n, input logic cmp);
    for (int i = 0; i < n; i++) begin
      host.pop(got, ok);
      if (ok !== 1'b1) begin
        chk(36'h0, 36'h1, "readout timeout");
        report_and_stop();
      end
      if (cmp) begin
        chk(got, sent.pop_front(), "readout word");
      end
    end
  endtask
  task automatic fresh(input logic [7:0] mode);
    host.wr(OFS_COLLECTION_CTRL, 8'h00);
    host.wr(OFS_COLLECTION_CTRL, mode);
    sent.delete();
  endtask
  task automatic evt(input logic [2:0] e);
    step();
    trigEvents = trig_events_t'(e);
    step();
    trigEvents = trig_events_t'(3'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    activeBit = 1'b0;
    external_trigger_mode = 1'b0;
    autosleep_period_count = 16'h0000;
    outputRateTick = 1'b0;
    autoWakeEvt = 1'b0;
    autoSleepEvt = 1'b0;
    sleepBlocked = 1'b0;
    trigEvents = trig_events_t'(3'h0);
    sampleValid = 1'b0;
    sampleData = sample_t'(36'h0);
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    activeBit = 1'b1;
    foreach (addrs[i]) begin
      host.rd(addrs[i], rv);
      chk(36'(rv), 36'h0, "reset value");
    end
    repeat (4) begin
      v = 8'($random(seed));
      host.wr(OFS_COLLECTION_CTRL, v);
      host.rd(OFS_COLLECTION_CTRL, rv);
      chk(36'(rv), 36'(v & MASK_COLLECTION), "coll rw");
      host.wr(OFS_THRESHOLD_CTRL, v | 8'h80);
      host.rd(OFS_THRESHOLD_CTRL, rv);
      chk(36'(rv), 36'((v | 8'h80) & MASK_THRESHOLD), "thr rw");
      chk(36'(buffer_keeps_awake), 36'(v[6]), "keep awake");
    end
    $display("test registers done");
    fresh(8'h40);
    host.wr(OFS_THRESHOLD_CTRL, 8'h05);
    push(40);
    chk(36'(sampleCount), 36'(capCount(40)), "stop count");
    chk(36'(overflow_flag), 36'h1, "stop ovf");
    chk(36'(watermarkFlag), 36'h1, "wmrk");
    drain(DEPTH, 1'b1);
    $display("test stop done");
    fresh(8'h20);
    push(40);
    chk(36'(sampleCount), 36'(capCount(40)), "stream count");
    chk(36'(overflow_flag), 36'h1, "stream ovf");
    host.wr(OFS_COLLECTION_CTRL, 8'h00);
    step();
    step();
    chk(36'({overflow_flag, watermarkFlag, sampleCount}), 36'h0, "off");
    $display("test disable done");
    fresh(8'h20);
    host.wr(OFS_THRESHOLD_CTRL, 8'h00);
    push(10);
    chk(36'(watermarkFlag), 36'h0, "wmrk zero");
    host.wr(OFS_THRESHOLD_CTRL, 8'h80);
    step();
    step();
    chk(36'(sampleCount), 36'h0, "flush cmd");
    host.rd(OFS_THRESHOLD_CTRL, rv);
    chk(36'(rv), 36'h0, "flush bit");
    sent.delete();
    push(1);
    drain(1, 1'b1);
    push(3);
    activeBit = 1'b0;
    step();
    activeBit = 1'b1;
    step();
    step();
    chk(36'(sampleCount), 36'h0, "standby exit");
    push(2);
    activeBit = 1'b0;
    step();
    external_trigger_mode = 1'b1;
    step();
    step();
    chk(36'(sampleCount), 36'h0, "ext trigger exit");
    activeBit = 1'b1;
    external_trigger_mode = 1'b0;
    $display("test flush done");
    fresh(8'h30);
    push(5);
    step();
    autoWakeEvt = 1'b1;
    step();
    autoWakeEvt = 1'b0;
    push(3);
    chk(36'(sampleCount), 36'h5, "hold keeps");
    chk(36'({gateDropFlag, gateDropCount}), 36'h23, "gate drops");
    chk(36'(sampleReady), 36'h1, "ready while gated");
    drain(5, 1'b1);
    step();
    chk(36'({gateDropFlag, gateDropCount}), 36'h0, "gate clr");
    fresh(8'h20);
    push(4);
    step();
    autoSleepEvt = 1'b1;
    step();
    autoSleepEvt = 1'b0;
    step();
    step();
    chk(36'(sampleCount), 36'h0, "auto flush");
    $display("test gate done");
    host.wr(OFS_THRESHOLD_CTRL, 8'h04);
    for (int s = 0; s < 3; s++) begin
      fresh(8'h60 | ((s == 0) ? 8'h01 : (8'h02 << s)));
      push(6);
      evt(3'h7 & ~(3'h1 << s));
      push(6);
      chk(36'(sampleCount), 36'h4, "pre trigger");
      evt(3'h1 << s);
      push(40);
      evt(3'h1 << s);
      chk(36'(sampleCount), 36'(capCount(40)), "capture");
      chk(36'({overflow_flag, wakeMode}), 36'h3, "capt ovf");
      drain(DEPTH, 1'b0);
      step();
      chk(36'(overflow_flag), 36'h0, "rearm");
    end
    $display("test trigger done");
    fresh(8'h61);
    autosleep_period_count = 16'h0002;
    activeBit = 1'b0;
    step();
    activeBit = 1'b1;
    step();
    step();
    chk(36'(wakeMode), 36'h1, "wake at start");
    push(3);
    sleepBlocked = 1'b1;
    repeat (2) begin
      step();
      outputRateTick = 1'b1;
      step();
      outputRateTick = 1'b0;
    end
    step();
    chk(36'(wakeMode), 36'h1, "sleep blocked");
    sleepBlocked = 1'b0;
    step();
    step();
    chk(36'(wakeMode), 36'h0, "sleep");
    chk(36'(sampleCount), 36'h0, "sleep flush");
    $display("test autosleep done");
    report_and_stop();
  end
endmodule
